// File: omc_top.sv
/*
 Operating mode control: strap capture, mode decode, mode register with its
 write protections, bus configuration, E clock stretch control, wait
 shutdown, and debug memory overlay. Assumes straps come from pins and are
 synchronised here; everything else shares clk_sys.
*/
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module omc_top (
   // Clock, reset, enable.
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   input  wire logic                  clk_en,
   // Strap pins.
   input  wire logic                  background_debug_pin,
   input  wire logic                  mode_select_high,
   input  wire logic                  mode_select_low,
   // Register port.
   input  wire logic [15:0]           reg_addr,
   input  wire logic [7:0]            reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic [7:0]                 reg_rdata,
   // Processor side.
   input  wire omc_pkg::omc_cpu_acc_t cpu_acc,
   input  wire logic                  cpu_acc_ext,
   input  wire logic                  halt_to_debug_instruction,
   input  wire logic                  wait_mode,
   input  wire logic                  bus_busy,
   // Status and control outputs.
   output omc_pkg::omc_bus_cfg_t      bus_cfg,
   output omc_pkg::omc_map_t          map_sel,
   output logic                       cpu_halted,
   output logic                       dbg_active,
   output logic                       e_stretch_high,
   output logic                       e_stretch_low,
   output logic                       vis_drive,
   output logic                       vis_wide_data,
   output logic                       bus_shutdown
);

   // Synchronisers and the strap-capture pipeline.
   logic [2:0] strap_s1_ff;
   logic [2:0] strap_s2_ff;
   logic       first_ff;

   // Mode register state.
   logic [2:0] mode_ff;
   logic       e_clock_stretch_enable_ff;
   logic       internal_visibility_ff;
   logic       ebsw_ff;
   logic       eme_ff;
   // Written records: special_mode_not, mode bits, e_clock_stretch_enable, internal_visibility, eme.
   logic [4:0] wr_seen_ff;
   // Debug and wait state.
   logic       dbg_en_ff;
   logic       dbg_act_ff;
   logic [3:0] wait_cnt_ff;

   logic       special;
   logic       expanded;
   logic       hit_mode;
   logic       wr_mode;
   logic [2:0] nxt_mode;
   logic [7:0] mode_rd;
   logic [2:0] cap_mode;
   logic       ctl_wr;

   // How the block hangs together. The strap pins are sampled through a
   // two-flop synchroniser that keeps running while reset is held, so the
   // settled strap levels sit in the second flop when reset falls. The first
   // enabled edge after release takes them into the mode bits; every other
   // field that depends on the mode takes its reset value at that same edge.
   // Each field of the mode register has its own write rule. One record per
   // field but the wait shutdown bit remembers whether a write has been accepted since reset, which
   // gives both write-once in normal modes and first-write-ignored in special
   // modes from the same flop. All outputs are registered, so every status
   // output trails the mode bits by one cycle; software that changes mode
   // must allow that cycle before it relies on the bus configuration.

   // Expanded means the external bus exists: narrow or wide codes.
   function automatic logic is_expanded(input logic [2:0] m);
      is_expanded = (m[0] == 1'b1);
   endfunction

   // Normal reserved code is forced to peripheral.
   function automatic logic [2:0] fold_mode(input logic [2:0] m);
      fold_mode = (m == omc_pkg::OMC_NM_RSV) ? omc_pkg::OMC_SP_PER : m;
   endfunction

   // Write-once in normal modes, anytime but the first in special modes.
   function automatic logic late_or_once(input logic spc, input logic seen);
      late_or_once = spc ? seen : !seen;
   endfunction

   assign special  = ~mode_ff[2];
   assign expanded = is_expanded(mode_ff);
   assign hit_mode = (reg_addr == omc_pkg::OMC_REG_OFFSET) && (mode_ff != omc_pkg::OMC_SP_PER);
   assign wr_mode  = reg_wr && hit_mode;
   // Folded strap code, the mode that the first enabled edge will capture.
   assign cap_mode = fold_mode(strap_s2_ff);
   assign ctl_wr   = reg_wr && (reg_addr == omc_pkg::OMC_CTRL_OFFSET);

   // Pins are asynchronous, so they pass two flops before use. These two have
   // no reset on purpose: they keep sampling while reset is held, so settled
   // strap levels stand in the second flop when reset is released.
   always_ff @(posedge clk_sys)
   begin
      if (clk_en)
      begin
         strap_s1_ff <= {background_debug_pin, mode_select_high, mode_select_low};
         strap_s2_ff <= strap_s1_ff;
      end
   end

   // First enabled cycle after release; straps are taken here, not at reset.
   // Taking them one edge late costs a cycle of start-up but avoids a race.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         first_ff <= 1'b1;
      else if (clk_en)
         first_ff <= 1'b0;
   end

   // Proposed mode bits from a write, honouring the protections.
   // In normal modes the special bit never changes, so a program cannot
   // fall into a test mode by accident.
   always_comb
   begin
      nxt_mode = mode_ff;
      if (special)
      begin
         if (wr_seen_ff[0])
            nxt_mode[2] = reg_wdata[omc_pkg::OMC_B_SPECIAL_MODE_NOT];
         if (wr_seen_ff[1])
            nxt_mode[1:0] = {reg_wdata[omc_pkg::OMC_B_MODE_SELECT_HIGH], reg_wdata[omc_pkg::OMC_B_MODE_SELECT_LOW]};
      end
      else if (!wr_seen_ff[1])
         nxt_mode[1:0] = {reg_wdata[omc_pkg::OMC_B_MODE_SELECT_HIGH], reg_wdata[omc_pkg::OMC_B_MODE_SELECT_LOW]};
      // Peripheral comes only from straps; writes never select it or reserved.
      if ((nxt_mode == omc_pkg::OMC_SP_PER) || (nxt_mode == omc_pkg::OMC_NM_RSV))
         nxt_mode = mode_ff;
   end

   // Mode status bits.
   // Peripheral mode is left only through reset, so no write reaches them there.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         mode_ff <= omc_pkg::OMC_SP_PER;
      else if (clk_en)
      begin
         if (first_ff)
            mode_ff <= fold_mode(strap_s2_ff);
         else if (wr_mode && (mode_ff != omc_pkg::OMC_SP_PER))
            mode_ff <= nxt_mode;
      end
   end

   // Configuration bits; visibility and emulation reset values follow the captured mode. Stretch may
   // be written once in normal modes and at any time in special modes, wait
   // shutdown only in normal modes, and visibility and emulation once in
   // normal modes but never by the first write in special modes. The stored
   // stretch bit is kept as written; expanded modes override it on use.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         e_clock_stretch_enable_ff <= omc_pkg::OMC_RST_E_CLOCK_STRETCH_ENABLE;
         ebsw_ff <= omc_pkg::OMC_RST_EBSW;
         internal_visibility_ff <= 1'b0;
         eme_ff  <= 1'b0;
      end
      else if (clk_en)
      begin
         if (first_ff)
         begin
            // The folded code is used, so a reserved strap resets as special.
            internal_visibility_ff <= ~cap_mode[2];
            eme_ff  <= ~cap_mode[2];
         end
         else if (wr_mode)
         begin
            if (special || !wr_seen_ff[2])
               e_clock_stretch_enable_ff <= reg_wdata[omc_pkg::OMC_B_E_CLOCK_STRETCH_ENABLE];
            if (late_or_once(special, wr_seen_ff[3]))
               internal_visibility_ff <= reg_wdata[omc_pkg::OMC_B_INTERNAL_VISIBILITY];
            if (late_or_once(special, wr_seen_ff[4]))
               eme_ff <= reg_wdata[omc_pkg::OMC_B_EME];
            if (!special)
               ebsw_ff <= reg_wdata[omc_pkg::OMC_B_EBSW];
         end
      end
   end

   // Written records, one per protected field, cleared by reset.
   // One accepted write marks every field, even a field that the write
   // itself could not change.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         wr_seen_ff <= 5'h00;
      else if (clk_en && wr_mode && !first_ff)
         wr_seen_ff <= 5'h1F;
   end

   // Debug control: enable, activation by command or halt, exit by command.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         dbg_en_ff  <= 1'b0;
         dbg_act_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         if (first_ff)
         begin
            dbg_en_ff  <= (cap_mode == omc_pkg::OMC_SP_SC);
            dbg_act_ff <= (cap_mode == omc_pkg::OMC_SP_SC);
         end
         else
         begin
            if (ctl_wr)
               dbg_en_ff <= reg_wdata[omc_pkg::OMC_B_DBG_EN];
            // Entry wins over exit: with debug already enabled, a halt that meets a
            // control write in the same cycle still enters debug and is not dropped.
            if ((ctl_wr && reg_wdata[omc_pkg::OMC_B_DBG_EN]
                 && reg_wdata[omc_pkg::OMC_B_DBG_CMD])
                || (dbg_en_ff && halt_to_debug_instruction))
               dbg_act_ff <= 1'b1;
            else if (ctl_wr && !reg_wdata[omc_pkg::OMC_B_DBG_EN])
               dbg_act_ff <= 1'b0;
         end
      end
   end

   // Wait shutdown counts quiet cycles so pending bus activity finishes.
   // Any bus activity restarts the count, so the interface never stops in
   // the middle of a cycle.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         wait_cnt_ff <= 4'h0;
      else if (clk_en)
      begin
         if (!(wait_mode && ebsw_ff) || bus_busy)
            wait_cnt_ff <= 4'h0;
         else if (wait_cnt_ff != omc_pkg::OMC_WAIT_SHUT_CYC)
            wait_cnt_ff <= wait_cnt_ff + 4'h1;
      end
   end

   // Readback image of the mode register; bit 1 reads as zero.
   always_comb
   begin
      mode_rd = 8'h00;
      mode_rd[omc_pkg::OMC_B_SPECIAL_MODE_NOT] = mode_ff[2];
      mode_rd[omc_pkg::OMC_B_MODE_SELECT_HIGH]  = mode_ff[1];
      mode_rd[omc_pkg::OMC_B_MODE_SELECT_LOW]  = mode_ff[0];
      mode_rd[omc_pkg::OMC_B_E_CLOCK_STRETCH_ENABLE]  = e_clock_stretch_enable_ff | expanded;
      mode_rd[omc_pkg::OMC_B_INTERNAL_VISIBILITY]  = internal_visibility_ff;
      mode_rd[omc_pkg::OMC_B_EBSW]  = ebsw_ff;
      mode_rd[omc_pkg::OMC_B_EME]   = eme_ff;
   end

   // Read data one cycle after the strobe; unmapped addresses read zero.
   // The data drop back to zero after one cycle, so a late sample sees zero
   // rather than stale data.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         reg_rdata <= 8'h00;
      else if (clk_en)
      begin
         reg_rdata <= 8'h00;
         if (reg_rd)
         begin
            if (hit_mode)
               reg_rdata <= mode_rd;
            else if (reg_addr == omc_pkg::OMC_ID_OFFSET)
               reg_rdata <= omc_pkg::OMC_ID_VALUE;
            else if (reg_addr == omc_pkg::OMC_CTRL_OFFSET)
               reg_rdata <= {6'h00, dbg_act_ff, dbg_en_ff};
            else if (reg_addr == omc_pkg::OMC_STAT_OFFSET)
               reg_rdata <= {4'h0, wait_cnt_ff};
         end
      end
   end

   // Bus configuration and E clock behaviour, all registered.
   // Registering costs one cycle of lag behind the mode bits but keeps the
   // outputs free of glitches.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         bus_cfg        <= '0;
         cpu_halted     <= 1'b1;
         e_stretch_high <= 1'b0;
         e_stretch_low  <= 1'b0;
         vis_drive      <= 1'b0;
         vis_wide_data  <= 1'b0;
         bus_shutdown   <= 1'b0;
      end
      else if (clk_en)
      begin
         bus_cfg.special     <= special;
         bus_cfg.single_chip <= (mode_ff[1:0] == 2'b00);
         bus_cfg.ext_bus     <= expanded;
         bus_cfg.wide        <= (mode_ff[1:0] == 2'b11);
         bus_cfg.narrow      <= (mode_ff[1:0] == 2'b01);
         bus_cfg.periph      <= (mode_ff == omc_pkg::OMC_SP_PER);
         cpu_halted          <= (mode_ff == omc_pkg::OMC_SP_PER) || first_ff;
         e_stretch_high <= (e_clock_stretch_enable_ff | expanded) && cpu_acc.valid && cpu_acc_ext;
         e_stretch_low  <= (e_clock_stretch_enable_ff | expanded) && cpu_acc.valid && !cpu_acc_ext
                           && !(internal_visibility_ff && expanded);
         vis_drive      <= internal_visibility_ff && expanded && cpu_acc.valid && !cpu_acc_ext;
         vis_wide_data  <= internal_visibility_ff && (mode_ff == omc_pkg::OMC_SP_EN)
                           && cpu_acc.valid && !cpu_acc_ext;
         bus_shutdown   <= (wait_cnt_ff == omc_pkg::OMC_WAIT_SHUT_CYC);
      end
   end

   // Resource map selects for the current access.
   // The selects lag the access by one cycle. Serial debug accesses still
   // reach the top user page, which a debug host needs in order to inspect
   // the user memory hidden behind the debug window.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         map_sel    <= '0;
         dbg_active <= 1'b0;
      end
      else if (clk_en)
      begin
         dbg_active <= dbg_act_ff;
         map_sel.dbg_rom <= dbg_act_ff && !cpu_acc.serial
                            && (cpu_acc.addr >= omc_pkg::OMC_DBG_ROM_LO);
         map_sel.dbg_reg <= dbg_act_ff && (cpu_acc.addr >= omc_pkg::OMC_DBG_REG_LO)
                            && (cpu_acc.addr <= omc_pkg::OMC_DBG_REG_HI);
         map_sel.user_hidden <= dbg_act_ff && !cpu_acc.serial
                                && (cpu_acc.addr[15:8] == omc_pkg::OMC_TOP_PAGE);
         map_sel.port_e_mapped <= (mode_ff != omc_pkg::OMC_SP_PER)
                                  && !(eme_ff && expanded);
         map_sel.mode_reg_mapped <= (mode_ff != omc_pkg::OMC_SP_PER);
      end
   end

endmodule // omc_top
`default_nettype wire

// File: omc_pkg.sv
/*
 Package for the operating mode control block: register offset, field
 positions, mode encodings, debug map window constants and carrier structs.
 Assumes a single system clock domain and a plain strobe register port.
*/
package omc_pkg;

   // Register map.
   localparam logic [15:0] OMC_REG_OFFSET   = 16'h000B;
   localparam logic [15:0] OMC_ID_OFFSET    = 16'h000C;
   localparam logic [15:0] OMC_CTRL_OFFSET  = 16'h000D;
   localparam logic [15:0] OMC_STAT_OFFSET  = 16'h000E;

   // Field positions of the mode register.
   localparam int OMC_B_SPECIAL_MODE_NOT  = 7;
   localparam int OMC_B_MODE_SELECT_HIGH   = 6;
   localparam int OMC_B_MODE_SELECT_LOW   = 5;
   localparam int OMC_B_E_CLOCK_STRETCH_ENABLE   = 4;
   localparam int OMC_B_INTERNAL_VISIBILITY   = 3;
   localparam int OMC_B_EBSW   = 2;
   localparam int OMC_B_EME    = 0;

   // Field positions of the debug control register.
   localparam int OMC_B_DBG_EN  = 0;
   localparam int OMC_B_DBG_CMD = 1;

   // Reset values of the stretch and wait shutdown bits.
   localparam logic OMC_RST_E_CLOCK_STRETCH_ENABLE = 1'b1;
   localparam logic OMC_RST_EBSW = 1'b0;

   // Arbitrary neutral identity value.
   localparam logic [7:0] OMC_ID_VALUE = 8'h5A;

   // Debug map windows.
   localparam logic [15:0] OMC_DBG_ROM_LO = 16'hFF20;
   localparam logic [15:0] OMC_DBG_REG_LO = 16'hFF00;
   localparam logic [15:0] OMC_DBG_REG_HI = 16'hFF06;
   localparam logic [7:0]  OMC_TOP_PAGE   = 8'hFF;

   // Cycles the bus interface waits in wait mode before shutting down.
   localparam logic [3:0] OMC_WAIT_SHUT_CYC = 4'h8;

   // Mode codes {special_mode_not, mode_select_high, mode_select_low}.
   typedef enum logic [2:0] {
      OMC_SP_SC  = 3'b000,
      OMC_SP_EN  = 3'b001,
      OMC_SP_PER = 3'b010,
      OMC_SP_EW  = 3'b011,
      OMC_NM_SC  = 3'b100,
      OMC_NM_EN  = 3'b101,
      OMC_NM_RSV = 3'b110,
      OMC_NM_EW  = 3'b111
   } omc_mode_t;

   // Port usage per mode.
   typedef struct packed {
      logic ext_bus;
      logic wide;
      logic narrow;
      logic periph;
      logic single_chip;
      logic special;
   } omc_bus_cfg_t;

   // Processor access seen by the map decoder.
   typedef struct packed {
      logic        valid;
      logic        serial;
      logic [15:0] addr;
   } omc_cpu_acc_t;

   // Map selects.
   typedef struct packed {
      logic dbg_rom;
      logic dbg_reg;
      logic user_hidden;
      logic port_e_mapped;
      logic mode_reg_mapped;
   } omc_map_t;

endpackage

// File: omc_asserts.sv
/*
 Checker for omc_top: mode, map, read-back and wait shutdown relations.
 Assumes it is bound to omc_top and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
module omc_asserts (
   // Clock and reset.
   input wire logic                  clk_sys,
   input wire logic                  rst,
   // Observed ports.
   input wire logic [15:0]           reg_addr,
   input wire logic                  reg_rd,
   input wire logic [7:0]            reg_rdata,
   input wire omc_pkg::omc_cpu_acc_t cpu_acc,
   input wire logic                  wait_mode,
   input wire logic                  bus_busy,
   input wire omc_pkg::omc_bus_cfg_t bus_cfg,
   input wire omc_pkg::omc_map_t     map_sel,
   input wire logic                  cpu_halted,
   input wire logic                  dbg_active,
   input wire logic                  vis_drive,
   input wire logic                  bus_shutdown
);
   // One domain, so one clock and one reset serve every property.
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // A read strobe aimed at the mode register.
   sequence s_mode_rd;
      reg_rd && reg_addr == omc_pkg::OMC_REG_OFFSET;
   endsequence
   // An ordinary processor access to the top page while debug runs.
   sequence s_top_acc;
      dbg_active && cpu_acc.valid && !cpu_acc.serial && cpu_acc.addr[15:8] == 8'hFF;
   endsequence
   property p_periph_halt;
      bus_cfg.periph |-> cpu_halted;
   endproperty
   a_periph_halt: assert property (p_periph_halt)
      else $error("processor active in peripheral mode");
   property p_sc_quiet;
      bus_cfg.single_chip |-> !bus_cfg.ext_bus && !vis_drive;
   endproperty
   a_sc_quiet: assert property (p_sc_quiet)
      else $error("bus activity in single-chip mode");
   property p_e_clock_stretch_enable_forced;
      s_mode_rd ##0 (bus_cfg.ext_bus && !bus_cfg.periph) |=> reg_rdata[4];
   endproperty
   a_e_clock_stretch_enable_forced: assert property (p_e_clock_stretch_enable_forced)
      else $error("stretch enable reads 0 in expanded mode");
   property p_periph_gone;
      s_mode_rd ##0 bus_cfg.periph |=> reg_rdata == 8'h00;
   endproperty
   a_periph_gone: assert property (p_periph_gone)
      else $error("mode register visible in peripheral mode");
   property p_dbg_rom;
      s_top_acc ##0 cpu_acc.addr >= omc_pkg::OMC_DBG_ROM_LO |=> map_sel.dbg_rom;
   endproperty
   a_dbg_rom: assert property (p_dbg_rom)
      else $error("debug rom not selected");
   property p_hidden;
      s_top_acc |=> map_sel.user_hidden;
   endproperty
   a_hidden: assert property (p_hidden)
      else $error("top user page reachable during debug");
   property p_shut_quiet;
      $rose(bus_shutdown) |-> $past(wait_mode) && !$past(bus_busy);
   endproperty
   a_shut_quiet: assert property (p_shut_quiet)
      else $error("bus shut down during activity or outside wait");
   property p_narrow_one;
      bus_cfg.narrow |-> !bus_cfg.wide && bus_cfg.ext_bus;
   endproperty
   a_narrow_one: assert property (p_narrow_one)
      else $error("narrow and wide bus both selected");
endmodule // omc_asserts
bind omc_top omc_asserts u_chk (.clk_sys, .rst, .reg_addr, .reg_rd, .reg_rdata, .cpu_acc,
   .wait_mode, .bus_busy, .bus_cfg, .map_sel, .cpu_halted, .dbg_active, .vis_drive,
   .bus_shutdown);
`default_nettype wire

// File: omc_ext_mem.sv
/*
 External memory model on the expanded bus: busy while accessed and while
 the remaining bytes of a transfer finish. Assumes one request level.
*/
`timescale 1ns/1ps
`default_nettype none
module omc_ext_mem (
   // Clock and reset.
   input  wire logic clk_sys,
   input  wire logic rst,
   // Access from the bus.
   input  wire logic req,
   input  wire logic narrow,
   // Activity seen by the block.
   output logic      bus_busy
);
   logic [1:0] left_ff;
   // A narrow word goes high byte then low byte, so it stays busy longer.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         left_ff <= 2'h0;
      else if (req)
         left_ff <= narrow ? 2'h2 : 2'h1;
      else if (left_ff != 2'h0)
         left_ff <= left_ff - 2'h1;
   end
   // Busy while requested and while bytes remain pending.
   assign bus_busy = req || left_ff != 2'h0;
endmodule // omc_ext_mem
`default_nettype wire

// File: omc_top_tb.sv
/*
 Self-checking bench for omc_top: strap decode, register protections, debug
 overlay and wait shutdown. Assumes omc_ext_mem answers external cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
   $display("BAD %s exp %h got %h", n, e, g); end end
module omc_top_tb;
   localparam logic [15:0] mr_a  = omc_pkg::OMC_REG_OFFSET;
   localparam logic [15:0] ctl_a = omc_pkg::OMC_CTRL_OFFSET;
   logic        clk_sys = 1'b0, rst = 1'b1, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic        background_debug_pin = 1'b1, mode_select_high = 1'b0, mode_select_low = 1'b0;
   logic        halt_to_debug_instruction = 1'b0, wait_mode = 1'b0, cpu_acc_ext = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0]  reg_wdata = 8'h00, reg_rdata;
   logic        bus_busy, cpu_halted, dbg_active, e_stretch_high, e_stretch_low;
   logic        vis_drive, vis_wide_data, bus_shutdown;
   int          err_total = 0, n_checks = 0, cyc = 0;
   omc_pkg::omc_cpu_acc_t cpu_acc = {1'b1, 1'b0, 16'h1000};
   omc_pkg::omc_bus_cfg_t bus_cfg;
   omc_pkg::omc_map_t     map_sel;
   // Free-running system clock.
   always #25 clk_sys = ~clk_sys;
   omc_top DUT (.clk_sys, .rst, .clk_en, .background_debug_pin, .mode_select_high,
      .mode_select_low, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_acc,
      .cpu_acc_ext, .halt_to_debug_instruction, .wait_mode, .bus_busy, .bus_cfg, .map_sel,
      .cpu_halted, .dbg_active, .e_stretch_high, .e_stretch_low, .vis_drive, .vis_wide_data,
      .bus_shutdown);
   omc_ext_mem u_mem (.clk_sys, .rst, .req(cpu_acc.valid && cpu_acc_ext),
      .narrow(bus_cfg.narrow), .bus_busy);
   task automatic conclude;
      if (err_total == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Straps held three cycles around the reset release, as the synchroniser needs.
   task automatic boot(input logic [2:0] m);
      @(posedge clk_sys);
      {background_debug_pin, mode_select_high, mode_select_low} <= m;
      rst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so sample there.
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      `CHK("reg_rdata", e, reg_rdata)
   endtask
   task automatic halt;
      @(posedge clk_sys);
      halt_to_debug_instruction <= 1'b1;
      @(posedge clk_sys);
      halt_to_debug_instruction <= 1'b0;
      repeat (2) @(negedge clk_sys);
   endtask
   // Map selects lag the access by one cycle.
   task automatic acc(input logic [15:0] a, input logic sr);
      @(posedge clk_sys);
      cpu_acc <= {1'b1, sr, a};
      repeat (2) @(negedge clk_sys);
   endtask
   // Cut a hang short; the run needs well under a thousand cycles.
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         err_total++;
         conclude();
      end
   end
   initial
   begin
      logic [2:0] m;
      logic       s;
      logic [5:0] cfg;
      for (int i = 0; i < 8; i++)
      begin
         m = 3'(i);
         s = ~m[2];
         boot(m);
         `CHK("dbg_active", m == 3'b000, dbg_active)
         `CHK("periph", m[1:0] == 2'b10, bus_cfg.periph)
         `CHK("reg_map", m[1:0] != 2'b10, map_sel.mode_reg_mapped)
         if (m[1:0] == 2'b10)
         begin
            // The processor stays halted while the test master owns the bus.
            `CHK("halted", 1'b1, cpu_halted)
            wr(mr_a, 8'h60);
            rd(mr_a, 8'h00);
            `CHK("periph", 1'b1, bus_cfg.periph)
         end
         else
         begin
            rd(mr_a, {m, 1'b1, s, 1'b0, 1'b0, s});
            cfg = {m[0], m[1:0] == 2'b11, m[1:0] == 2'b01, 1'b0, m[1:0] == 2'b00, s};
            `CHK("bus_cfg", cfg, bus_cfg)
            `CHK("port_e", ~(s & m[0]), map_sel.port_e_mapped)
            `CHK("vis", s & m[0], vis_drive)
            `CHK("vis_wide", m == 3'b001, vis_wide_data)
            `CHK("stretch", {1'b0, ~(s & m[0])}, {e_stretch_high, e_stretch_low})
            `CHK("halted", 1'b0, cpu_halted)
         end
      end
      for (int k = 0; k < 2; k++)
      begin
         boot(3'b100);
         wr(mr_a, 8'h8D);
         rd(mr_a, 8'h8D);
      end
      `CHK("stretch_lo", 1'b0, e_stretch_low)
      wr(mr_a, 8'hB0);
      rd(mr_a, 8'h89);
      wr(ctl_a, 8'h02);
      halt();
      `CHK("dbg_active", 1'b0, dbg_active)
      wr(ctl_a, 8'h01);
      halt();
      `CHK("dbg_active", 1'b1, dbg_active)
      wr(ctl_a, 8'h00);
      wr(ctl_a, 8'h01);
      wr(ctl_a, 8'h03);
      rd(ctl_a, 8'h03);
      boot(3'b000);
      acc(16'hFF30, 1'b0);
      `CHK("rom", 2'b10, {map_sel.dbg_rom, map_sel.dbg_reg})
      acc(16'hFF06, 1'b0);
      `CHK("dreg", 2'b01, {map_sel.dbg_rom, map_sel.dbg_reg})
      acc(16'hFF10, 1'b1);
      `CHK("hide", 1'b0, map_sel.user_hidden)
      acc(16'hFF10, 1'b0);
      `CHK("hide", 1'b1, map_sel.user_hidden)
      acc(16'h1000, 1'b0);
      wr(mr_a, 8'h60);
      rd(mr_a, 8'h09);
      wr(mr_a, 8'h64);
      rd(mr_a, 8'h70);
      `CHK("wide", 1'b1, bus_cfg.wide)
      wr(mr_a, 8'h40);
      rd(mr_a, 8'h70);
      boot(3'b101);
      @(posedge clk_sys);
      cpu_acc_ext <= 1'b1;
      wr(mr_a, 8'hA4);
      rd(mr_a, 8'hB4);
      `CHK("stretch_hi", 1'b1, e_stretch_high)
      @(posedge clk_sys);
      wait_mode <= 1'b1;
      cpu_acc_ext <= 1'b0;
      repeat (2) @(negedge clk_sys);
      `CHK("shutdown", 1'b0, bus_shutdown)
      repeat (9) @(negedge clk_sys);
      `CHK("shutdown", 1'b0, bus_shutdown)
      repeat (7) @(negedge clk_sys);
      `CHK("shutdown", 1'b1, bus_shutdown)
      @(posedge clk_sys);
      wait_mode <= 1'b0;
      repeat (3) @(negedge clk_sys);
      `CHK("shutdown", 1'b0, bus_shutdown)
      conclude();
   end
endmodule // omc_top_tb
`default_nettype wire
